/* hdl/radio_link_cfg.svh */
// Offsets, checksum mode codes, reset values and timing figures of the radio link control block
`ifndef RADIO_LINK_CFG_SVH
`define RADIO_LINK_CFG_SVH
// ==========================================
// Register byte offsets
`define RL_CTRL_OFS 7'h00
`define RL_DELAY_OFS 7'h04
`define RL_STATUS_OFS 7'h08
`define RL_POWER_OFS 7'h0C
`define RL_MAIN_KEY_OFS 7'h10
`define RL_AUX_KEY_OFS 7'h14
`define RL_HASH_OFS 7'h18
// ==========================================
// Reset values
`define RL_CTRL_RST 8'h00
`define RL_DELAY_RST 16'h0000
`define RL_POWER_RST 16'h03E8
// ==========================================
// Checksum mode codes in the control register
`define RL_CHK_OFF 2'h0
`define RL_CHK_PART8 2'h1
`define RL_CHK_FULL16 2'h2
`define RL_CHK_FULL8 2'h3
// ==========================================
// Timing and last suffix character index
`define RL_CLK_HZ 25000000
`define RL_ENC_LAT128_MS 16'h0005
`define RL_ENC_LAT256_MS 16'h000A
`define RL_PAUSE_US 3125
`define RL_SFX_LAST 5'h10
`endif

/* hdl/radio_link_packet_control.sv */
// Link-layer packet control of a radio modem: settings, transmit scheduling and receive delivery
// What this block does
// - Encrypt each packet alone with AES-CTR
// - Encryption adds 5 or 10 ms latency
// - Encryption enable resets to off
// - Key from main, aux and packet nonce
// - Keys unreadable; hash exposes four hex digits
// - Receive-only state; power query returns zero
// - Factory receive-only lock ignores user writes
// - Priority defaults to transmit
// - Transmit priority aborts reception immediately
// - Receive priority waits for reception end
// - FEC adds redundancy, corrects received errors
// - FEC mismatch means received data dropped
// - Check off forwards received data immediately
// - Partial CRC8 releases good blocks only
// - Full checks buffer packet, forward if good
// - CRC8 checksums reach serial output only with check off, where every checksum byte with matching FEC is forwarded
// - CRC16 passes through when check off
// - Transmit start delayed 0 to 65535 ms
// - No switch to receive during delay
// - Append framed RSSI suffix after messages
// - Transmit ends after pause and empty buffer
`timescale 1ns/1ps
`default_nettype none
`include "radio_link_cfg.svh"
module radio_link_packet_control #(
  parameter int TX_DEPTH = 1024,
  parameter int RX_DEPTH = 1024,
  parameter int MS_CYCLES = `RL_CLK_HZ / 1000,
  parameter int PAUSE_CYCLES = `RL_PAUSE_US * (`RL_CLK_HZ / 1000000)
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Factory strap
  input wire logic fac_rx_only_i,
  // Terminal side
  input wire logic ser_valid_i,
  input wire logic [7:0] ser_data_i,
  output logic ser_ready_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i,
  // Modulator and cipher core
  output logic tx_on_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic tx_encrypt_o,
  output logic enc_256_o,
  output logic [63:0] tx_nonce_o,
  output logic [255:0] main_key_o,
  output logic [255:0] aux_key_o,
  output logic fec_en_o,
  // Demodulator
  input wire logic rx_busy_i,
  input wire logic rx_valid_i,
  input wire radio_link_pkg::rx_beat_s rx_beat_i,
  input wire logic [7:0] rssi_i,
  output logic rx_ready_o,
  output logic rx_abort_o,
  output logic rx_hold_o
);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);

  // Key hash: xor fold of both keys into 16 bits
  function automatic logic [15:0] key_hash(input logic [255:0] a, input logic [255:0] b);
    logic [15:0] h;
    h = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      h = {h[14:0], h[15]} ^ a[i*16 +: 16] ^ {b[i*16 +: 8], b[i*16+8 +: 8]};
    end
    return h;
  endfunction : key_hash

  // Suffix character n of "\02RSSI:-nnn dBm\03\0D\0A"
  function automatic logic [7:0] sfx_char(input logic [4:0] n, input logic [7:0] r);
    logic [7:0] hun;
    logic [7:0] ten;
    logic [7:0] one;
    hun = 8'h30 + r / 8'h64;
    ten = 8'h30 + (r / 8'h0A) % 8'h0A;
    one = 8'h30 + r % 8'h0A;
    case (n)
      5'h00: return 8'h02;
      5'h01: return 8'h52;
      5'h02: return 8'h53;
      5'h03: return 8'h53;
      5'h04: return 8'h49;
      5'h05: return 8'h3A;
      5'h06: return 8'h2D;
      5'h07: return hun;
      5'h08: return ten;
      5'h09: return one;
      5'h0A: return 8'h20;
      5'h0B: return 8'h64;
      5'h0C: return 8'h42;
      5'h0D: return 8'h6D;
      5'h0E: return 8'h03;
      5'h0F: return 8'h0D;
      default: return 8'h0A;
    endcase
  endfunction : sfx_char

  // ==========================================
  // Register file
  radio_link_pkg::cfg_s cfg, next_cfg;
  logic [15:0] delay_ms, next_delay_ms, power_mw, next_power_mw;
  logic [255:0] main_key, next_main_key, aux_key, next_aux_key;
  logic main_set, next_main_set, aux_set, next_aux_set, next_ack;
  logic [31:0] next_dat;
  logic wr_en;
  radio_link_pkg::tx_state_e ts;
  radio_link_pkg::rx_state_e rs;
  logic rx_dropped;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_comb begin
    next_cfg = cfg;
    next_delay_ms = delay_ms;
    next_power_mw = power_mw;
    next_main_key = main_key;
    next_aux_key = aux_key;
    next_main_set = main_set;
    next_aux_set = aux_set;
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = 32'h0000_0000;
    if (wr_en) begin
      case (wb_adr_i)
        `RL_CTRL_OFS: if (wb_sel_i[0]) next_cfg = wb_dat_i[7:0];
        `RL_DELAY_OFS: begin
          if (wb_sel_i[0]) next_delay_ms[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_delay_ms[15:8] = wb_dat_i[15:8];
        end
        `RL_POWER_OFS: begin
          if (wb_sel_i[0]) next_power_mw[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_power_mw[15:8] = wb_dat_i[15:8];
        end
        `RL_MAIN_KEY_OFS: begin
          next_main_key = {main_key[223:0], wb_dat_i};
          next_main_set = 1'b1;
        end
        `RL_AUX_KEY_OFS: begin
          next_aux_key = {aux_key[223:0], wb_dat_i};
          next_aux_set = 1'b1;
        end
        default: next_cfg = cfg;
      endcase
    end
    // factory lock overrides user radio state
    if (fac_rx_only_i) next_cfg.rx_only = 1'b1;
    if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      case (wb_adr_i)
        `RL_CTRL_OFS: next_dat = {24'h000000, cfg};
        `RL_DELAY_OFS: next_dat = {16'h0000, delay_ms};
        `RL_STATUS_OFS: next_dat = {24'h000000, rx_dropped, aux_set && main_set, 2'(rs), 2'(ts), rx_busy_i, tx_on_o};
        `RL_POWER_OFS: next_dat = cfg.rx_only ? 32'h0000_0000 : {16'h0000, power_mw};
        // keys read as zero, hash only
        `RL_HASH_OFS: next_dat = {16'h0000, key_hash(main_key, aux_key)};
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= `RL_CTRL_RST;
      delay_ms <= `RL_DELAY_RST;
      power_mw <= `RL_POWER_RST;
      main_key <= '0;
      aux_key <= '0;
      main_set <= 1'b0;
      aux_set <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      cfg <= next_cfg;
      delay_ms <= next_delay_ms;
      power_mw <= next_power_mw;
      main_key <= next_main_key;
      aux_key <= next_aux_key;
      main_set <= next_main_set;
      aux_set <= next_aux_set;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end
  assign main_key_o = main_key;
  assign aux_key_o = aux_key;

  // ==========================================
  // Transmit path
  logic [7:0] tx_mem [TX_DEPTH];
  logic [TAW-1:0] tx_wr, next_tx_wr, tx_rd, next_tx_rd;
  logic [TAW:0] tx_cnt, next_tx_cnt;
  logic [15:0] ms_cnt, next_ms_cnt, ms_left, next_ms_left;
  logic [19:0] idle, next_idle;
  logic [63:0] nonce, next_nonce;
  radio_link_pkg::cfg_s txcfg, next_txcfg;
  radio_link_pkg::tx_state_e next_ts;
  logic txv, next_txv, next_abort, push, pop, tick, paused;
  logic [7:0] txd, next_txd;

  assign ser_ready_o = tx_cnt != (TAW+1)'(TX_DEPTH);
  assign push = ser_valid_i && ser_ready_o;
  assign pop = (ts == radio_link_pkg::T_SEND) && (tx_cnt != '0) && (!txv || tx_ready_i);
  assign tick = ms_cnt == 16'(MS_CYCLES - 1);
  assign paused = idle == 20'(PAUSE_CYCLES);

  always_comb begin
    next_ts = ts;
    next_txcfg = txcfg;
    next_nonce = nonce;
    next_ms_cnt = tick ? 16'h0000 : ms_cnt + 16'h0001;
    next_ms_left = ms_left;
    next_abort = 1'b0;
    next_idle = push ? 20'h00000 : (paused ? idle : idle + 20'h00001);
    next_tx_wr = push ? tx_wr + TAW'(1) : tx_wr;
    next_tx_rd = pop ? tx_rd + TAW'(1) : tx_rd;
    next_tx_cnt = tx_cnt + (TAW+1)'(push) - (TAW+1)'(pop);
    next_txv = (txv && tx_ready_i) ? 1'b0 : txv;
    next_txd = txd;
    if (pop) begin
      next_txv = 1'b1;
      next_txd = tx_mem[tx_rd];
    end
    case (ts)
      radio_link_pkg::T_IDLE: begin
        // no start when receive-only or while receiving under receive priority
        if (tx_cnt != '0 && !cfg.rx_only && !(cfg.prio_rx && rx_busy_i) &&
            !(cfg.enc_en && !(main_set && aux_set))) begin
          next_txcfg = cfg;
          next_abort = rx_busy_i;
          next_nonce = nonce + 64'h1;
          next_ms_cnt = 16'h0000;
          next_ms_left = delay_ms;
          next_ts = radio_link_pkg::T_DELAY;
        end
      end
      radio_link_pkg::T_DELAY: begin
        if (ms_left == 16'h0000) begin
          next_ms_left = txcfg.enc_256 ? `RL_ENC_LAT256_MS : `RL_ENC_LAT128_MS;
          next_ms_cnt = 16'h0000;
          next_ts = txcfg.enc_en ? radio_link_pkg::T_CRYPT : radio_link_pkg::T_SEND;
        end else if (tick) begin
          next_ms_left = ms_left - 16'h0001;
        end
      end
      radio_link_pkg::T_CRYPT: begin
        if (ms_left == 16'h0000) next_ts = radio_link_pkg::T_SEND;
        else if (tick) next_ms_left = ms_left - 16'h0001;
      end
      radio_link_pkg::T_SEND: begin
        // end only after a pause and an empty buffer
        if (tx_cnt == '0 && !txv && paused) next_ts = radio_link_pkg::T_IDLE;
      end
      default: next_ts = radio_link_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts <= radio_link_pkg::T_IDLE;
      txcfg <= `RL_CTRL_RST;
      nonce <= 64'h0;
      ms_cnt <= 16'h0000;
      ms_left <= 16'h0000;
      idle <= 20'h00000;
      tx_wr <= '0;
      tx_rd <= '0;
      tx_cnt <= '0;
      txv <= 1'b0;
      txd <= 8'h00;
      rx_abort_o <= 1'b0;
    end else if (ce_i) begin
      ts <= next_ts;
      txcfg <= next_txcfg;
      nonce <= next_nonce;
      ms_cnt <= next_ms_cnt;
      ms_left <= next_ms_left;
      idle <= next_idle;
      tx_wr <= next_tx_wr;
      tx_rd <= next_tx_rd;
      tx_cnt <= next_tx_cnt;
      txv <= next_txv;
      txd <= next_txd;
      rx_abort_o <= next_abort;
      if (push) tx_mem[tx_wr] <= ser_data_i;
    end
  end
  assign tx_on_o = ts == radio_link_pkg::T_SEND;
  assign tx_valid_o = txv;
  assign tx_data_o = txd;
  // cipher core runs per packet in counter mode
  assign tx_encrypt_o = txcfg.enc_en;
  assign enc_256_o = txcfg.enc_256;
  // 64-bit nonce string with 256-bit keys, else 32
  assign tx_nonce_o = txcfg.enc_256 ? nonce : {32'h0, nonce[31:0]};
  // redundancy and correction are in the modem
  assign fec_en_o = txcfg.fec_en;
  // receive held off from delay to end of send
  assign rx_hold_o = ts != radio_link_pkg::T_IDLE;

  // ==========================================
  // Receive path
  logic [7:0] rx_mem [RX_DEPTH];
  logic [RAW:0] rx_wr, next_rx_wr, rx_rd, next_rx_rd;
  logic [4:0] sfx, next_sfx;
  logic [7:0] rssi, next_rssi, next_od;
  logic in_pkt, next_in_pkt, discard, next_discard, pkt_done, next_pkt_done;
  logic sent, next_sent, next_ov, next_dropped, take, drop, store, chk_off;
  radio_link_pkg::cfg_s rxcfg, next_rxcfg, c;
  radio_link_pkg::rx_state_e next_rs;

  assign rx_ready_o = (rs == radio_link_pkg::R_RECV) && !out_valid_o && (rx_wr != (RAW+1)'(RX_DEPTH));
  assign take = rx_valid_i && rx_ready_o;
  assign c = in_pkt ? rxcfg : cfg;
  assign chk_off = c.chk == `RL_CHK_OFF;
  // FEC setting must match the sender
  assign drop = discard || (rx_beat_i.fec != c.fec_en);
  assign store = take && !drop && !chk_off && !rx_beat_i.crc_byte;

  always_comb begin
    next_rs = rs;
    next_rxcfg = rxcfg;
    next_in_pkt = in_pkt;
    next_discard = discard;
    next_pkt_done = pkt_done;
    next_rx_wr = store ? rx_wr + (RAW+1)'(1) : rx_wr;
    next_rx_rd = rx_rd;
    next_sfx = sfx;
    next_rssi = rssi;
    next_sent = sent;
    next_dropped = rx_dropped;
    next_ov = (out_valid_o && out_ready_i) ? 1'b0 : out_valid_o;
    next_od = out_data_o;
    case (rs)
      radio_link_pkg::R_RECV: begin
        if (take) begin
          if (!in_pkt) next_rxcfg = cfg;
          next_in_pkt = !rx_beat_i.pkt_end;
          next_pkt_done = rx_beat_i.pkt_end;
          if (drop) next_dropped = 1'b1;
          // check off: every byte with matching FEC straight out
          if (chk_off && !drop) begin
            next_ov = 1'b1;
            next_od = rx_beat_i.data;
            next_sent = 1'b1;
          end
          // partial: release good blocks, discard after a bad one
          if (c.chk == `RL_CHK_PART8 && (rx_beat_i.blk_end || rx_beat_i.pkt_end)) begin
            if (rx_beat_i.check_ok && !drop) next_rs = radio_link_pkg::R_DRAIN;
            else begin
              next_discard = 1'b1;
              next_rx_wr = '0;
            end
          end
          // full: whole packet held, released only if good
          if (!chk_off && c.chk != `RL_CHK_PART8 && rx_beat_i.pkt_end) begin
            if (rx_beat_i.check_ok && !drop) next_rs = radio_link_pkg::R_DRAIN;
            else next_rx_wr = '0;
          end
          if (rx_beat_i.pkt_end) begin
            next_rssi = rssi_i;
            next_discard = 1'b0;
            if (next_rs == radio_link_pkg::R_RECV && c.rssi_app && (next_sent || !chk_off && 1'b0)) begin
              next_sfx = 5'h00;
              next_rs = radio_link_pkg::R_SUFFIX;
            end else if (next_rs == radio_link_pkg::R_RECV) next_sent = 1'b0;
          end
        end
      end
      radio_link_pkg::R_DRAIN: begin
        if (!out_valid_o || out_ready_i) begin
          if (rx_rd == rx_wr) begin
            next_rx_wr = '0;
            next_rx_rd = '0;
            next_ov = 1'b0;
            if (pkt_done && rxcfg.rssi_app && sent) begin
              next_sfx = 5'h00;
              next_rs = radio_link_pkg::R_SUFFIX;
            end else begin
              next_sent = sent && !pkt_done;
              next_rs = radio_link_pkg::R_RECV;
            end
          end else begin
            next_ov = 1'b1;
            next_od = rx_mem[rx_rd[RAW-1:0]];
            next_rx_rd = rx_rd + (RAW+1)'(1);
            next_sent = 1'b1;
          end
        end
      end
      radio_link_pkg::R_SUFFIX: begin
        // framed strength text after the message
        if (!out_valid_o || out_ready_i) begin
          next_ov = 1'b1;
          next_od = sfx_char(sfx, rssi);
          next_sfx = sfx + 5'h01;
          if (sfx == `RL_SFX_LAST) begin
            next_sent = 1'b0;
            next_rs = radio_link_pkg::R_RECV;
          end
        end
      end
      default: next_rs = radio_link_pkg::R_RECV;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs <= radio_link_pkg::R_RECV;
      rxcfg <= `RL_CTRL_RST;
      in_pkt <= 1'b0;
      discard <= 1'b0;
      pkt_done <= 1'b0;
      rx_wr <= '0;
      rx_rd <= '0;
      sfx <= 5'h00;
      rssi <= 8'h00;
      sent <= 1'b0;
      rx_dropped <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= 8'h00;
    end else if (ce_i) begin
      rs <= next_rs;
      rxcfg <= next_rxcfg;
      in_pkt <= next_in_pkt;
      discard <= next_discard;
      pkt_done <= next_pkt_done;
      rx_wr <= next_rx_wr;
      rx_rd <= next_rx_rd;
      sfx <= next_sfx;
      rssi <= next_rssi;
      sent <= next_sent;
      rx_dropped <= next_dropped;
      out_valid_o <= next_ov;
      out_data_o <= next_od;
      if (store) rx_mem[rx_wr[RAW-1:0]] <= rx_beat_i.data;
    end
  end

  // ==========================================
  // Checks
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_reset_defaults: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> !cfg.enc_en && !cfg.prio_rx) else $error("wrong settings after reset");
  a_power_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `RL_POWER_OFS && cfg.rx_only
    |=> wb_ack_o && wb_dat_o == 32'h0) else $error("power query not zero in receive-only");
  a_key_hidden: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == `RL_MAIN_KEY_OFS
    |=> wb_dat_o == 32'h0) else $error("key readable");
  a_factory_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && fac_rx_only_i |=> cfg.rx_only ##1 !tx_on_o || txcfg.rx_only == 1'b0)
    else $error("factory receive-only lock not kept");
  a_prio_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ts == radio_link_pkg::T_IDLE && cfg.prio_rx && rx_busy_i |=> ts == radio_link_pkg::T_IDLE)
    else $error("transmit started during reception");
  a_delay_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ts == radio_link_pkg::T_DELAY |-> rx_hold_o && !tx_on_o) else $error("receive allowed during delay");
  a_fec_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && take && rx_beat_i.fec != c.fec_en |=> !out_valid_o) else $error("FEC mismatch data delivered");
endmodule : radio_link_packet_control
`default_nettype wire

/* hdl/radio_link_pkg.sv */
// Types shared by the radio link control block
package radio_link_pkg;
  // Link settings, bit 0 is enc_en
  typedef struct packed {
    logic rssi_app;
    logic [1:0] chk;
    logic fec_en;
    logic prio_rx;
    logic rx_only;
    logic enc_256;
    logic enc_en;
  } cfg_s;
  // One received byte from the demodulator with its framing marks
  typedef struct packed {
    logic [7:0] data;
    logic crc_byte;
    logic blk_end;
    logic pkt_end;
    logic check_ok;
    logic fec;
  } rx_beat_s;
  typedef enum logic [1:0] {T_IDLE, T_DELAY, T_CRYPT, T_SEND} tx_state_e;
  typedef enum logic [1:0] {R_RECV, R_DRAIN, R_SUFFIX} rx_state_e;
endpackage : radio_link_pkg

/* test/air_peer_model.sv */
// Model of the peer modulator that takes transmit bytes with a stalling ready
`timescale 1ns/1ps
`default_nettype none
module air_peer_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte stream from the block
  input wire logic tx_on_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic [7:0] last_o,
  output logic [7:0] count_o
);
  // ==========================================
  // Stall every other cycle so a held byte is exercised; no bytes while unkeyed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      last_o <= 8'h00;
      count_o <= 8'h00;
    end else begin
      tx_ready_o <= tx_on_i & ~tx_ready_o;
      if (tx_on_i && tx_valid_i && tx_ready_o) begin
        last_o <= tx_data_i;
        count_o <= count_o + 8'h01;
      end
    end
  end
endmodule : air_peer_model
`default_nettype wire

/* test/radio_link_packet_control_tb.sv */
// Self-checking bench of the radio link packet control block
`timescale 1ns/1ps
`default_nettype none
`include "radio_link_cfg.svh"
module radio_link_packet_control_tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, fac = 0, ser_v = 0, rx_busy = 0, rx_v = 0, ce = 1, out_rdy = 1;
  logic [6:0] adr = 7'h00;
  logic [3:0] sel = 4'hF;
  logic [255:0] mkey;
  logic [31:0] dat_w = 32'h0, rd, q;
  logic [7:0] ser_d = 8'h00, rssi = 8'h57, out_d, tx_d, p_last, p_cnt, o_last;
  radio_link_pkg::rx_beat_s beat = '0;
  logic ack, ser_rdy, out_v, tx_on, tx_v, tx_rdy, tx_enc, rx_rdy, rx_abort, rx_hold, ab_seen;
  int bad_count = 0, n_checks = 0, ocnt = 0, base, n;
  initial forever #20 clk = ~clk;
  radio_link_packet_control #(.TX_DEPTH(16), .RX_DEPTH(16), .MS_CYCLES(4), .PAUSE_CYCLES(8)) dut_u (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(rd), .wb_ack_o(ack), .fac_rx_only_i(fac),
    .ser_valid_i(ser_v), .ser_data_i(ser_d), .ser_ready_o(ser_rdy), .out_valid_o(out_v),
    .out_data_o(out_d), .out_ready_i(out_rdy), .tx_on_o(tx_on), .tx_valid_o(tx_v), .tx_data_o(tx_d),
    .tx_ready_i(tx_rdy), .tx_encrypt_o(tx_enc), .enc_256_o(), .tx_nonce_o(), .main_key_o(mkey),
    .aux_key_o(), .fec_en_o(), .rx_busy_i(rx_busy), .rx_valid_i(rx_v), .rx_beat_i(beat),
    .rssi_i(rssi), .rx_ready_o(rx_rdy), .rx_abort_o(rx_abort), .rx_hold_o(rx_hold));
  air_peer_model peer_u (.clk_i(clk), .rst_i(rst), .tx_on_i(tx_on), .tx_valid_i(tx_v),
    .tx_data_i(tx_d), .tx_ready_o(tx_rdy), .last_o(p_last), .count_o(p_cnt));
  // ==========================================
  // Serial output and abort monitors
  always_ff @(posedge clk) begin
    if (out_v && out_rdy) begin
      ocnt <= ocnt + 1;
      o_last <= out_d;
    end
    ab_seen <= rst ? 1'b0 : (ab_seen | rx_abort);
  end
  task automatic stop_test;
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // ==========================================
  // Classic Wishbone single cycle; the answer is awaited, not assumed
  task automatic wb(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdc(input string nm, input logic [6:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rdc
  task automatic ser_put(input logic [7:0] d);
    @(posedge clk);
    ser_v <= 1'b1;
    ser_d <= d;
    do @(posedge clk); while (ser_rdy !== 1'b1);
    ser_v <= 1'b0;
  endtask : ser_put
  task automatic rx_put(input logic [7:0] d, input logic [4:0] f);
    @(posedge clk);
    rx_v <= 1'b1;
    beat <= {d, f};
    do @(posedge clk); while (rx_rdy !== 1'b1);
    rx_v <= 1'b0;
  endtask : rx_put
  task automatic tx_wait;
    n = 0;
    while (tx_on !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask : tx_wait
  task automatic rx_case(input logic [7:0] ctrl, input int exp, input logic [7:0] last);
    wb(1'b1, `RL_CTRL_OFS, {24'h0, ctrl});
    repeat (40) @(posedge clk);
    chk("out_count", ocnt - base, exp);
    if (exp > 0) chk("out_last", o_last, last);
    base = ocnt;
  endtask : rx_case
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc("ctrl", `RL_CTRL_OFS, 32'h0);
    rdc("delay", `RL_DELAY_OFS, 32'h0);
    rdc("power", `RL_POWER_OFS, 32'h3E8);
    rdc("unmapped", 7'h1C, 32'h0);
    wb(1'b1, `RL_MAIN_KEY_OFS, 32'hA5A5A5A5);
    rdc("key_read", `RL_MAIN_KEY_OFS, 32'h0);
    wb(1'b1, `RL_CTRL_OFS, 32'h04);
    rdc("power_rxonly", `RL_POWER_OFS, 32'h0);
    fac <= 1'b1;
    wb(1'b1, `RL_CTRL_OFS, 32'h00);
    rdc("ctrl_locked", `RL_CTRL_OFS, 32'h04);
    fac <= 1'b0;
    base = ocnt;
    rx_put(8'hA5, 5'h16);
    rx_case(8'h00, 1, 8'hA5);
    rx_put(8'hB6, 5'h07);
    rx_case(8'h60, 0, 8'h00);
    rx_put(8'h11, 5'h00);
    rx_put(8'h22, 5'h00);
    rx_put(8'h33, 5'h16);
    rx_case(8'h40, 2, 8'h22);
    rx_put(8'h44, 5'h04);
    rx_case(8'h20, 0, 8'h00);
    rx_put(8'h55, 5'h0A);
    rx_put(8'h66, 5'h08);
    rx_put(8'h77, 5'h06);
    rx_case(8'h80, 1, 8'h55);
    rx_put(8'h99, 5'h06);
    // Terminal stalls: the suffix must be held, not lost or repeated
    out_rdy <= 1'b0;
    repeat (5) @(posedge clk);
    out_rdy <= 1'b1;
    rx_case(8'h01, 18, 8'h0A);
    // Encryption on with the aux key not yet written, and a zero delay
    wb(1'b1, `RL_DELAY_OFS, 32'h0);
    ser_put(8'h3C);
    repeat (30) @(posedge clk);
    chk("tx_nokeys", tx_on, 1'b0);
    wb(1'b1, `RL_MAIN_KEY_OFS, 32'h01234567);
    wb(1'b1, `RL_AUX_KEY_OFS, 32'h89ABCDEF);
    tx_wait;
    chk("crypt_wait", n >= 16 && n < 40, 1'b1);
    chk("tx_encrypt", tx_enc, 1'b1);
    chk("key_low", mkey[31:0], 32'h01234567);
    chk("key_high", mkey[63:32], 32'hA5A5A5A5);
    repeat (60) @(posedge clk);
    chk("tx_byte", p_last, 8'h3C);
    chk("tx_ended", tx_on, 1'b0);
    // Delayed start under transmit priority cuts a reception short
    wb(1'b1, `RL_CTRL_OFS, 32'h00);
    // Upper lane masked off: only the low byte of the delay lands
    sel <= 4'h1;
    wb(1'b1, `RL_DELAY_OFS, 32'h0000_7703);
    sel <= 4'hF;
    rdc("delay_lane", `RL_DELAY_OFS, 32'h3);
    rx_busy <= 1'b1;
    ser_put(8'h5A);
    repeat (2) @(negedge clk);
    chk("rx_hold", rx_hold, 1'b1);
    // Freeze mid-delay: the count must resume, not run on
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    tx_wait;
    chk("delay_len", n >= 10 && n < 30, 1'b1);
    chk("abort", ab_seen, 1'b1);
    repeat (60) @(posedge clk);
    chk("tx_byte2", p_last, 8'h5A);
    // Receive priority waits for the reception to end
    wb(1'b1, `RL_DELAY_OFS, 32'h0);
    wb(1'b1, `RL_CTRL_OFS, 32'h08);
    ser_put(8'hC3);
    repeat (30) @(posedge clk);
    chk("rx_prio_wait", tx_on, 1'b0);
    rx_busy <= 1'b0;
    tx_wait;
    chk("rx_prio_go", n < 20, 1'b1);
    repeat (60) @(posedge clk);
    chk("tx_byte3", p_last, 8'hC3);
    chk("tx_count", p_cnt, 8'h03);
    stop_test;
  end
endmodule : radio_link_packet_control_tb
`default_nettype wire
